// [src/psc_power_ctrl.v]
`timescale 1ns/1ps
`default_nettype none
`include "psc_defs.vh"

module psc_power_ctrl (
   input  wire                   clk,
   input  wire                   rst_n,
   input  wire                   serialClkPin,
   input  wire                   chipSelPin_n,
   input  wire                   serialInPin,
   output reg                    serialOutPin,
   output reg                    serialOutOe_n,
   input  wire                   runModePin,
   input  wire                   switchTwoGateInput,
   input  wire                   resetSenseLow,
   input  wire                   lowBatterySenseLow,
   input  wire                   channelCompareHigh,
   input  wire                   syncPin,
   output reg                    resetOutput,
   output reg                    resetOutputOe_n,
   output reg                    lowBatteryOutput,
   output reg                    lowBatteryOutputOe_n,
   output reg                    switchOneOutput,
   output reg                    switchOneOutputOe_n,
   output reg                    switchTwoOutput,
   output reg                    switchTwoOutputOe_n,
   output reg                    runMode,
   output reg                    boostEnable,
   output reg                    backupCellToRegulator,
   output reg                    thirdRegulatorEnable,
   output reg                    chargeCurrentHigh,
   output reg  [4:0]             voutDacCode,
   output reg                    logicSupplyClamp,
   output reg  [6:0]             channelDacCode,
   output reg                    channelDacPowerDown,
   output wire                   pwmTick,
   output wire                   syncLocked
);

   // Decode of the clamp threshold, used twice
   function clampOf;
      input [4:0] code;
      begin
         clampOf = (code >= `PSC_VOUT_CLAMP);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for every outside input
   reg  [8:0] syncA_ff;
   reg  [8:0] syncB_ff;
   reg        sclkD_ff;
   reg        csD_ff;
   reg        syncD_ff;

   always @(posedge clk) begin
      if (!rst_n) begin
         syncA_ff <= 9'h002;                                // Clock low, CS high
         syncB_ff <= 9'h002;
      end else begin
         syncA_ff <= {syncPin, channelCompareHigh, lowBatterySenseLow,
                      resetSenseLow, switchTwoGateInput, runModePin,
                      serialInPin, chipSelPin_n, 1'b0} |
                     {8'h00, serialClkPin} |
                     9'h000;
         syncB_ff <= syncA_ff;
      end
   end

   wire sclkS  = syncB_ff[0];
   wire csS_n  = syncB_ff[1];
   wire sdiS   = syncB_ff[2];
   wire runS   = syncB_ff[3];
   wire gateS  = syncB_ff[4];
   wire rstSnS = syncB_ff[5];
   wire lowBS  = syncB_ff[6];
   wire chS    = syncB_ff[7];
   wire syncS  = syncB_ff[8];

   // Edge detectors on the synchronised levels
   always @(posedge clk) begin
      if (!rst_n) begin
         sclkD_ff <= 1'b0;
         csD_ff   <= 1'b1;
         syncD_ff <= 1'b0;
      end else begin
         sclkD_ff <= sclkS;
         csD_ff   <= csS_n;
         syncD_ff <= syncS;
      end
   end

   wire sclkRise = sclkS & ~sclkD_ff;
   wire sclkFall = ~sclkS & sclkD_ff;
   wire csFall   = ~csS_n & csD_ff;
   wire csRise   = csS_n & ~csD_ff;
   wire syncRise = syncS & ~syncD_ff;

   // Internal power-on reset: pin reset or reset comparator
   wire porClr = !rst_n || rstSnS;

   ////////////////////////////////////////////////////////////////////////
   // Serial shifter, mode 0, MSB first
   reg  [`PSC_FRAME_BITS-1:0] rxShift_ff;
   reg  [`PSC_FRAME_BITS-1:0] txShift_ff;
   reg  [`PSC_CNT_W-1:0]      bitCnt_ff;
   wire [`PSC_FRAME_BITS-1:0] rdWord;
   wire                       chResult;

   assign chResult = chS & (channelDacCode != 7'h00);
   assign rdWord   = {chResult, lowBS, 22'h000000};

   always @(posedge clk) begin
      if (porClr) begin
         rxShift_ff <= {`PSC_FRAME_BITS{1'b0}};
         txShift_ff <= {`PSC_FRAME_BITS{1'b0}};
         bitCnt_ff  <= {`PSC_CNT_W{1'b0}};
      end else if (csFall) begin
         txShift_ff <= rdWord;
         bitCnt_ff  <= {`PSC_CNT_W{1'b0}};
      end else if (!csS_n) begin
         if (sclkRise) begin
            rxShift_ff <= {rxShift_ff[`PSC_FRAME_BITS-2:0], sdiS};
            if (bitCnt_ff != 5'h1F)
               bitCnt_ff <= bitCnt_ff + 5'h01;
         end else if (sclkFall) begin
            txShift_ff <= {txShift_ff[`PSC_FRAME_BITS-2:0], 1'b0};
         end
      end
   end

   // Data out and its enable, driven only while selected
   always @(posedge clk) begin
      if (porClr) begin
         serialOutPin  <= 1'b0;
         serialOutOe_n <= 1'b1;
      end else begin
         serialOutPin  <= txShift_ff[`PSC_FRAME_BITS-1];
         serialOutOe_n <= csS_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers, committed on a complete frame
   reg  [4:0] voutCode_ff;
   reg  [6:0] dacCode_ff;
   reg        runBit_ff;
   reg        sw1Bit_ff;
   reg        sw2EnBit_ff;
   reg        backupBit_ff;
   reg        reg3Bit_ff;
   reg        chgHiBit_ff;
   wire       commit = csRise && (bitCnt_ff == `PSC_FRAME_CNT);

   always @(posedge clk) begin
      if (porClr) begin
         voutCode_ff  <= `PSC_VOUT_POR;
         dacCode_ff   <= `PSC_DAC_POR;
         runBit_ff    <= 1'b0;
         sw1Bit_ff    <= 1'b0;
         sw2EnBit_ff  <= 1'b0;
         backupBit_ff <= 1'b0;
         reg3Bit_ff   <= 1'b0;
         chgHiBit_ff  <= 1'b0;
      end else if (commit) begin
         dacCode_ff   <= rxShift_ff[`PSC_F_DAC_HI:`PSC_F_DAC_LO];
         voutCode_ff  <= rxShift_ff[`PSC_F_VOUT_HI:`PSC_F_VOUT_LO];
         runBit_ff    <= rxShift_ff[`PSC_F_RUN];
         sw1Bit_ff    <= rxShift_ff[`PSC_F_SW1];
         sw2EnBit_ff  <= rxShift_ff[`PSC_F_SW2EN];
         backupBit_ff <= rxShift_ff[`PSC_F_BACKUP];
         reg3Bit_ff   <= rxShift_ff[`PSC_F_THIRD_LINEAR_REGULATOR];
         chgHiBit_ff  <= rxShift_ff[`PSC_F_CHGHI];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output stage, one flop after registers and pins
   always @(posedge clk) begin
      if (!rst_n) begin
         resetOutput           <= 1'b0;
         resetOutputOe_n       <= 1'b0;
         lowBatteryOutput      <= 1'b0;
         lowBatteryOutputOe_n  <= 1'b1;
         switchOneOutput       <= 1'b0;
         switchOneOutputOe_n   <= 1'b1;
         switchTwoOutput       <= 1'b0;
         switchTwoOutputOe_n   <= 1'b1;
         runMode               <= 1'b0;
         boostEnable           <= 1'b1;
         backupCellToRegulator <= 1'b0;
         thirdRegulatorEnable  <= 1'b0;
         chargeCurrentHigh     <= 1'b0;
         voutDacCode           <= `PSC_VOUT_POR;
         logicSupplyClamp      <= clampOf(`PSC_VOUT_POR);
         channelDacCode        <= `PSC_DAC_POR;
         channelDacPowerDown   <= 1'b1;
      end else begin
         resetOutput           <= 1'b0;
         resetOutputOe_n       <= ~rstSnS;
         lowBatteryOutput      <= 1'b0;
         lowBatteryOutputOe_n  <= ~lowBS;
         switchOneOutput       <= 1'b0;
         switchOneOutputOe_n   <= ~sw1Bit_ff;
         switchTwoOutput       <= 1'b0;
         switchTwoOutputOe_n   <= ~(sw2EnBit_ff & gateS);
         runMode               <= runS | runBit_ff;
         boostEnable           <= ~backupBit_ff;
         backupCellToRegulator <= backupBit_ff;
         thirdRegulatorEnable  <= reg3Bit_ff;
         chargeCurrentHigh     <= chgHiBit_ff;
         voutDacCode           <= voutCode_ff;
         logicSupplyClamp      <= clampOf(voutCode_ff);
         channelDacCode        <= dacCode_ff;
         channelDacPowerDown   <= (dacCode_ff == 7'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Switching-rate generator locked to the sync pin
   psc_pwm_sync u_pwm (
      .clk           (clk),
      .rst_n         (rst_n),
      .syncRise      (syncRise),
      .pwmTick_ff    (pwmTick),
      .syncLocked_ff (syncLocked)
   );

endmodule // psc_power_ctrl
`default_nettype wire

// [common/psc_defs.vh]
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH

// Serial frame length and field positions
`define PSC_FRAME_BITS     24
`define PSC_FRAME_CNT      5'h18
`define PSC_CNT_W          5
`define PSC_F_DAC_HI       23
`define PSC_F_DAC_LO       17
`define PSC_F_VOUT_HI      16
`define PSC_F_VOUT_LO      12
`define PSC_F_RUN          11
`define PSC_F_SW1          10
`define PSC_F_SW2EN        9
`define PSC_F_BACKUP       8
`define PSC_F_THIRD_LINEAR_REGULATOR         7
`define PSC_F_CHGHI        6
`define PSC_F_RD_CH0       23
`define PSC_F_RD_LOWBAT    22

// Output-voltage code: 1.8 V at code 0, 100 mV steps, 4.9 V at 31
`define PSC_VOUT_MIN_MV    1800
`define PSC_VOUT_STEP_MV   100
`define PSC_VOUT_CLAMP_MV  3400
`define PSC_VOUT_CLAMP     5'h10
`define PSC_VOUT_POR       5'h0C

// Power-on values of the serial registers
`define PSC_DAC_POR        7'h00
`define PSC_CTRL_POR       6'h00

// Timing
`define PSC_CLK_HZ         40000000
`define PSC_FREE_HZ        270000
`define PSC_FREE_CYC       (`PSC_CLK_HZ / `PSC_FREE_HZ)
`define PSC_FREE_LAST      8'h93
`define PSC_PWM_MULT       3'h7
`define PSC_SYNC_TMO_CYC   12'hFFF
`define PSC_PER_W          12

`endif

// [src/psc_pwm_sync.v]
`timescale 1ns/1ps
`default_nettype none
`include "psc_defs.vh"

module psc_pwm_sync (
   input  wire                   clk,
   input  wire                   rst_n,
   input  wire                   syncRise,
   output reg                    pwmTick_ff,
   output reg                    syncLocked_ff
);

   reg  [`PSC_PER_W-1:0] perCnt_ff;
   reg  [`PSC_PER_W-1:0] period_ff;
   reg  [`PSC_PER_W+2:0] acc_ff;
   reg  [7:0]            freeCnt_ff;
   wire [`PSC_PER_W+2:0] accSum;

   assign accSum = acc_ff + {{`PSC_PER_W{1'b0}}, `PSC_PWM_MULT};

   ////////////////////////////////////////////////////////////////////////
   // Measure the sync period, drop lock on timeout
   always @(posedge clk) begin
      if (!rst_n) begin
         perCnt_ff     <= {`PSC_PER_W{1'b0}};
         period_ff     <= {`PSC_PER_W{1'b0}};
         syncLocked_ff <= 1'b0;
      end else if (syncRise) begin
         period_ff     <= perCnt_ff + 1'b1;
         perCnt_ff     <= {`PSC_PER_W{1'b0}};
         // A saturated count is no period: wait for the next edge
         syncLocked_ff <= (perCnt_ff != {`PSC_PER_W{1'b0}}) &&
                          (perCnt_ff != `PSC_SYNC_TMO_CYC);
      end else if (perCnt_ff == `PSC_SYNC_TMO_CYC) begin
         syncLocked_ff <= 1'b0;
      end else begin
         perCnt_ff <= perCnt_ff + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Seven ticks per sync period, else free-running rate
   always @(posedge clk) begin
      if (!rst_n) begin
         acc_ff     <= {(`PSC_PER_W+3){1'b0}};
         freeCnt_ff <= 8'h00;
         pwmTick_ff <= 1'b0;
      end else if (syncLocked_ff) begin
         freeCnt_ff <= 8'h00;
         if (accSum >= {3'b000, period_ff}) begin
            acc_ff     <= accSum - {3'b000, period_ff};
            pwmTick_ff <= 1'b1;
         end else begin
            acc_ff     <= accSum;
            pwmTick_ff <= 1'b0;
         end
      end else begin
         acc_ff <= {(`PSC_PER_W+3){1'b0}};
         if (freeCnt_ff == `PSC_FREE_LAST) begin
            freeCnt_ff <= 8'h00;
            pwmTick_ff <= 1'b1;
         end else begin
            freeCnt_ff <= freeCnt_ff + 8'h01;
            pwmTick_ff <= 1'b0;
         end
      end
   end

endmodule // psc_pwm_sync
`default_nettype wire

// [testbench/psc_power_ctrl_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level timing relations of the power control block
module psc_power_ctrl_checker (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       chipSelPin_n,
   input wire logic       runModePin,
   input wire logic       switchTwoGateInput,
   input wire logic       resetSenseLow,
   input wire logic       lowBatterySenseLow,
   input wire logic       serialOutOe_n,
   input wire logic       resetOutputOe_n,
   input wire logic       lowBatteryOutputOe_n,
   input wire logic       switchOneOutputOe_n,
   input wire logic       switchTwoOutputOe_n,
   input wire logic       runMode,
   input wire logic       boostEnable,
   input wire logic       backupCellToRegulator,
   input wire logic [4:0] voutDacCode,
   input wire logic       logicSupplyClamp,
   input wire logic [6:0] channelDacCode,
   input wire logic       channelDacPowerDown
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_RUN_PIN: assert property (runModePin [*5] |=> runMode)
      else $error("run pin high but coast selected");
   AST_SW2_GATE: assert property (!switchTwoGateInput [*5] |=> switchTwoOutputOe_n)
      else $error("switch two on with gate input low");
   AST_RST_OUT: assert property (resetSenseLow [*5] |=> !resetOutputOe_n)
      else $error("reset output not pulled low");
   AST_RST_POR: assert property (resetSenseLow [*6] |=> voutDacCode == 5'h0C
      && channelDacCode == 7'h00 && switchOneOutputOe_n)
      else $error("registers not at power-on state");
   AST_CLAMP: assert property ($stable(voutDacCode)
      |-> logicSupplyClamp == (voutDacCode >= 5'h10))
      else $error("clamp does not match voltage code");
   AST_DAC_PD: assert property ($stable(channelDacCode)
      |-> channelDacPowerDown == (channelDacCode == 7'h00))
      else $error("channel power-down does not match code");
   AST_BACKUP: assert property ($stable(backupCellToRegulator)
      |-> boostEnable != backupCellToRegulator)
      else $error("boost and backup regulate both on or off");
   AST_LOWBAT: assert property (lowBatterySenseLow [*5] |=> !lowBatteryOutputOe_n)
      else $error("low battery output not pulled low");
   AST_SDO_OE: assert property (chipSelPin_n [*5] |=> serialOutOe_n)
      else $error("serial out driven while deselected");
   AST_CFG_HOLD: assert property ((chipSelPin_n && !resetSenseLow) [*8]
      |=> $stable(voutDacCode))
      else $error("voltage code changed without a frame");
endmodule // psc_power_ctrl_checker

bind psc_power_ctrl psc_power_ctrl_checker i_psc_power_ctrl_checker (.*);
`default_nettype wire

// [testbench/psc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host side: mode 0 serial master, 8 clocks per bit
module psc_host_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [4:0]  nBits,
   input  wire logic [23:0] wrData,
   input  wire logic        serial_out_pin,
   output var  logic        sclk,
   output var  logic        csN,
   output var  logic        serial_in_pin,
   output var  logic [23:0] rdData,
   output var  logic        busy
);
   int          ph;
   int          nb;
   logic [23:0] sh;

   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      serial_in_pin = 1'b0;
      busy = 1'b0;
      rdData = 24'h0;
   end

   // Frame sequencer, MSB first, clock idles low
   always @(posedge clk) begin
      if (!busy) begin
         serial_in_pin <= ~serial_in_pin; // Released line keeps changing
         if (go) begin
            busy <= 1'b1;
            csN <= 1'b0;
            sh <= wrData;
            nb <= nBits;
            ph <= 0;
         end
      end else begin
         ph <= ph + 1;
         if (ph[2:0] == 3'h0 && ph >= 8) begin
            sclk <= 1'b0;
            serial_in_pin <= (ph <= 8 * nb) ? sh[23] : ~serial_in_pin;
            sh <= sh << 1;
         end
         if (ph[2:0] == 3'h4 && ph >= 12 && ph <= 8 * nb + 4)
            sclk <= 1'b1;
         if (ph[2:0] == 3'h7 && ph >= 15 && ph <= 8 * nb + 7)
            rdData <= {rdData[22:0], serial_out_pin};
         if (ph == 8 * nb + 12)
            csN <= 1'b1;
         if (ph == 8 * nb + 20)
            busy <= 1'b0;
      end
   end
endmodule // psc_host_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the power control block
module tb_top;
   logic        clk, rst_n, go, syncEn, runModePin, switchTwoGateInput;
   logic        resetSenseLow, lowBatterySenseLow, channelCompareHigh, syncPin;
   logic [4:0]  nBits;
   logic [6:0]  lastDac;
   logic [23:0] wrData, d, cur;
   logic [31:0] seed;
   int          nMismatch, comparisons, i, nTick, t0, syncCnt;
   wire logic   serialClkPin, chipSelPin_n, serialInPin, serialOutPin, busy;
   wire logic   serialOutOe_n, resetOutputOe_n, lowBatteryOutputOe_n, runMode;
   wire logic   switchOneOutputOe_n, switchTwoOutputOe_n, boostEnable, pwmTick;
   wire logic   backupCellToRegulator, thirdRegulatorEnable, chargeCurrentHigh;
   wire logic   logicSupplyClamp, channelDacPowerDown, hostSdo;
   wire logic   resetOutput, lowBatteryOutput, switchOneOutput;
   wire logic   switchTwoOutput, syncLocked;
   wire logic [4:0]  voutDacCode;
   wire logic [6:0]  channelDacCode;
   wire logic [23:0] rdData;

   psc_power_ctrl i_psc_power_ctrl (.*);
   psc_host_model i_psc_host_model (.clk, .go, .nBits, .wrData, .rdData,
      .busy, .serial_out_pin(hostSdo), .sclk(serialClkPin), .csN(chipSelPin_n),
      .serial_in_pin(serialInPin));
   // Deselected data line shows the inverse of its last level
   assign hostSdo = serialOutOe_n ? ~serialOutPin : serialOutPin;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         nMismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic checkAll(input logic [23:0] w);
      cmp(channelDacCode, w[23:17]);
      cmp(voutDacCode, w[16:12]);
      cmp(runMode, runModePin | w[11]);
      cmp(switchOneOutputOe_n, !w[10]);
      cmp(switchTwoOutputOe_n, !(w[9] & switchTwoGateInput));
      cmp({backupCellToRegulator, boostEnable}, {w[8], ~w[8]});
      cmp(thirdRegulatorEnable, w[7]);
      cmp(chargeCurrentHigh, w[6]);
      cmp(logicSupplyClamp, w[16:12] >= 5'h10);
      cmp(channelDacPowerDown, w[23:17] == 7'h00);
      cmp(lowBatteryOutputOe_n, !lowBatterySenseLow);
      cmp({resetOutput, lowBatteryOutput, switchOneOutput,
         switchTwoOutput}, 4'h0);
   endtask

   task automatic xfer(input logic [4:0] n, input logic [23:0] w);
      int t;
      nBits <= n;
      wrData <= w;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      t = 0;
      while (busy && t < 400) begin
         @(posedge clk);
         t++;
      end
      if (busy) nMismatch++;
      repeat (8) @(posedge clk);
   endtask

   task automatic closeOut;
      $display("mismatches=%0d comparisons=%0d", nMismatch, comparisons);
      if (nMismatch == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Sync source of 1400 clocks period and tick counter
   always @(posedge clk) begin
      syncCnt <= (syncEn && syncCnt < 699) ? syncCnt + 1 : 0;
      if (syncCnt == 699)
         syncPin <= ~syncPin;
      if (pwmTick)
         nTick <= nTick + 1;
   end

   initial begin
      repeat (40000) @(posedge clk);
      nMismatch++;
      closeOut();
   end

   // Main sequence
   initial begin
      {rst_n, go, syncEn, syncPin, runModePin, switchTwoGateInput} = 6'h00;
      {resetSenseLow, lowBatterySenseLow, channelCompareHigh} = 3'h0;
      {nBits, wrData, lastDac, syncCnt, nTick} = {5'h18, 31'h0, 64'h0};
      {nMismatch, comparisons, seed, cur} = {64'h0, 32'hAF677566, 24'h00C000};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      checkAll(cur);
      for (i = 0; i < 14; i++) begin
         seed = lfsr(seed);
         d = seed[23:0];
         case (i)
            0: d[23:12] = 12'h00F;
            1: d[16:12] = 5'h10;
            2: d[23:12] = 12'hFFF;
         endcase
         if (d[16:12] < 5'h07) d[16:12] = d[16:12] + 5'h07;
         {runModePin, switchTwoGateInput} <= seed[25:24];
         {channelCompareHigh, lowBatterySenseLow} <= seed[27:26];
         @(posedge clk);
         xfer(5'h18, d);
         checkAll(d);
         cmp(rdData, {channelCompareHigh && lastDac != 7'h00,
            lowBatterySenseLow, 22'h0});
         lastDac = d[23:17];
         cur = d;
      end
      xfer(5'h17, ~cur);
      checkAll(cur);
      resetSenseLow <= 1'b1;
      repeat (8) @(posedge clk);
      cmp(resetOutputOe_n, 1'b0);
      checkAll(24'h00C000);
      resetSenseLow <= 1'b0;
      repeat (8) @(posedge clk);
      cmp(resetOutputOe_n, 1'b1);
      // Free-running rate with no sync: one tick per 148 clocks
      t0 = nTick;
      repeat (1480) @(posedge clk);
      cmp((nTick - t0) inside {[9:11]}, 1'b1);
      cmp(syncLocked, 1'b0);
      syncEn <= 1'b1;
      repeat (5600) @(posedge clk);
      t0 = nTick;
      repeat (2800) @(posedge clk);
      cmp((nTick - t0) inside {[13:15]}, 1'b1);
      cmp(syncLocked, 1'b1);
      closeOut();
   end
endmodule // tb_top
`default_nettype wire
